// ### core/pwm_timer_shutdown.sv
// Top: APB registers, timebase select and auto-shutdown for one PWM module
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "pwm_shutdown_defines.svh"
module pwm_timer_shutdown (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic int_pin_n_in,
  input wire logic cmp1_async_n_in,
  input wire logic cmp2_async_n_in,
  input wire logic cmp3_async_n_in,
  input wire logic module_three_in,
  input wire logic comparator_sync_enable_in,
  input wire logic timer1_sync_tick_in,
  input wire logic timer2_match_in,
  input wire logic timer4_match_in,
  input wire logic timer6_match_in,
  input pwm_shutdown_pkg::pwm_pins_t pwm_in,
  output logic timebase_tick_out,
  output pwm_shutdown_pkg::pwm_pins_t pin_out,
  output pwm_shutdown_pkg::pwm_pins_t pin_oe_out,
  output logic irq_out
);
  //////////////////////////////////////////////////////////////////////////////
  // Register and state storage
  logic [1:0] tsel_reg;
  logic [1:0] tsel_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic restart_reg;
  logic restart_next;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_stat_next;
  logic [1:0] irq_en_reg;
  logic [1:0] irq_en_next;

  // APB answer
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;

  // Registered block outputs
  logic irq_reg;
  logic irq_next;
  logic tick_reg;
  logic tick_next;

  // Shutdown tracking
  logic cmp_hold_reg;
  logic cmp_hold_next;
  pwm_shutdown_pkg::shutdown_state_t state_reg;
  pwm_shutdown_pkg::shutdown_state_t state_next;
  pwm_shutdown_pkg::shutdown_inputs_t sync_n;

  // Qualified sources and bus decode
  logic [3:0] raw_n;
  logic cmp_src1_low;
  logic cmp_any_low;
  logic cmp_trip;
  logic event_active;
  logic apb_access;
  logic apb_write;
  logic status_write_zero;
  logic set_shutdown_ev;
  logic set_restart_ev;

  // Write strobes, one per writable register
  logic wr_tsel;
  logic wr_ctrl;
  logic wr_restart;
  logic wr_clear;
  logic wr_enable;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, one per shutdown input
  assign raw_n = {int_pin_n_in, cmp2_async_n_in, cmp3_async_n_in, cmp1_async_n_in};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      pin_sync3 u_sync (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .async_in(raw_n[gi]),
        .sync_out(sync_n[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Shutdown source qualification
  always_comb begin
    // Module three watches comparator three, others comparator two
    cmp_src1_low = module_three_in ? ~sync_n.cmp3 : ~sync_n.cmp2;
    cmp_any_low = (ctrl_reg[`BIT_SRC1] & cmp_src1_low)
                | (ctrl_reg[`BIT_SRC0] & ~sync_n.cmp1);
    // Sync option lets comparator trips act only on timer1 ticks
    cmp_trip = comparator_sync_enable_in ? cmp_hold_reg : cmp_any_low;
    event_active = (ctrl_reg[`BIT_SRC2] & ~sync_n.int_pin) | cmp_trip;
  end

  // Comparator level sampled on timer1 ticks
  always_comb begin
    cmp_hold_next = cmp_hold_reg;
    if (timer1_sync_tick_in) begin
      cmp_hold_next = cmp_any_low;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB decode and register next values
  assign apb_access = psel_in & penable_in & ~pready_reg;
  assign apb_write = apb_access & pwrite_in;
  assign status_write_zero = wr_ctrl & ~pwdata_in[`BIT_STATUS];

  // Write strobes; unmapped or read-only offsets strobe nothing
  always_comb begin
    wr_tsel = 1'b0;
    wr_ctrl = 1'b0;
    wr_restart = 1'b0;
    wr_clear = 1'b0;
    wr_enable = 1'b0;
    if (apb_write) begin
      if (paddr_in == `ADDR_TIMER_SELECT) begin
        wr_tsel = 1'b1;
      end else if (paddr_in == `ADDR_SHUTDOWN_CTRL) begin
        wr_ctrl = 1'b1;
      end else if (paddr_in == `ADDR_RESTART_CTRL) begin
        wr_restart = 1'b1;
      end else if (paddr_in == `ADDR_IRQ_CLEAR) begin
        wr_clear = 1'b1;
      end else if (paddr_in == `ADDR_IRQ_ENABLE) begin
        wr_enable = 1'b1;
      end
    end
  end

  // Writable fields; the status bit is owned by the state machine
  always_comb begin
    tsel_next = tsel_reg;
    ctrl_next = ctrl_reg;
    restart_next = restart_reg;
    irq_en_next = irq_en_reg;
    if (wr_tsel) begin
      tsel_next = pwdata_in[`TSEL_MSB:0];
    end
    if (wr_ctrl) begin
      ctrl_next[`BIT_SRC2:0] = pwdata_in[`BIT_SRC2:0];
    end
    if (wr_restart) begin
      restart_next = pwdata_in[`BIT_RESTART];
    end
    if (wr_enable) begin
      irq_en_next = pwdata_in[`IRQ_RESTART:0];
    end
    // Status bit follows the shutdown state machine
    ctrl_next[`BIT_STATUS] = (state_next != pwm_shutdown_pkg::run_st);
  end

  // Read data and error answer, one wait state after the access
  always_comb begin
    prdata_next = prdata_reg;
    pready_next = apb_access;
    pslverr_next = 1'b0;
    if (apb_access) begin
      if (paddr_in == `ADDR_TIMER_SELECT) begin
        prdata_next = {30'h0, tsel_reg};
      end else if (paddr_in == `ADDR_SHUTDOWN_CTRL) begin
        prdata_next = {24'h0, ctrl_reg};
      end else if (paddr_in == `ADDR_RESTART_CTRL) begin
        prdata_next = {31'h0, restart_reg};
      end else if (paddr_in == `ADDR_IRQ_STATUS) begin
        prdata_next = {30'h0, irq_stat_reg};
      end else if (paddr_in == `ADDR_IRQ_ENABLE) begin
        prdata_next = {30'h0, irq_en_reg};
      end else if (paddr_in == `ADDR_IRQ_CLEAR) begin
        // Write-only clear register reads as zero
        prdata_next = 32'h0;
      end else begin
        prdata_next = 32'h0;
        pslverr_next = 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shutdown state machine
  always_comb begin
    state_next = state_reg;
    set_shutdown_ev = 1'b0;
    set_restart_ev = 1'b0;
    case (state_reg)
      pwm_shutdown_pkg::run_st: begin
        if (event_active) begin
          state_next = pwm_shutdown_pkg::shut_st;
          set_shutdown_ev = 1'b1;
        end else if (wr_ctrl && pwdata_in[`BIT_STATUS]) begin
          // Software may force a shutdown by setting the status bit
          state_next = pwm_shutdown_pkg::shut_st;
          set_shutdown_ev = 1'b1;
        end
      end
      pwm_shutdown_pkg::shut_st: begin
        // Active source wins over a software clear
        if (event_active) begin
          state_next = pwm_shutdown_pkg::shut_st;
        end else if (restart_reg) begin
          state_next = pwm_shutdown_pkg::run_st;
          set_restart_ev = 1'b1;
        end else if (status_write_zero) begin
          state_next = pwm_shutdown_pkg::run_st;
          set_restart_ev = 1'b1;
        end else begin
          state_next = pwm_shutdown_pkg::wait_clear_st;
        end
      end
      pwm_shutdown_pkg::wait_clear_st: begin
        if (event_active) begin
          state_next = pwm_shutdown_pkg::shut_st;
        end else if (status_write_zero || restart_reg) begin
          state_next = pwm_shutdown_pkg::run_st;
          set_restart_ev = 1'b1;
        end
      end
      default: begin
        state_next = pwm_shutdown_pkg::shut_st;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status, set beats clear
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (wr_clear) begin
      irq_stat_next = irq_stat_reg & ~pwdata_in[1:0];
    end
    if (set_shutdown_ev) begin
      irq_stat_next[`IRQ_SHUTDOWN] = 1'b1;
    end
    if (set_restart_ev) begin
      irq_stat_next[`IRQ_RESTART] = 1'b1;
    end
    irq_next = |(irq_stat_next & irq_en_next);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Timebase selection; reserved code gives no tick
  always_comb begin
    case (tsel_reg)
      `TSEL_TIMER2: tick_next = timer2_match_in;
      `TSEL_TIMER4: tick_next = timer4_match_in;
      `TSEL_TIMER6: tick_next = timer6_match_in;
      default: tick_next = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Software registers; every implemented bit resets to zero
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      tsel_reg <= `TSEL_TIMER2;
      ctrl_reg <= `RESET_BYTE;
      restart_reg <= 1'b0;
      irq_en_reg <= 2'h0;
    end else begin
      tsel_reg <= tsel_next;
      ctrl_reg <= ctrl_next;
      restart_reg <= restart_next;
      irq_en_reg <= irq_en_next;
    end
  end

  // APB answer flops, quiet during reset
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Interrupt status and its level output
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      irq_stat_reg <= 2'h0;
      irq_reg <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_reg <= irq_next;
    end
  end

  // Shutdown state and held comparator sample
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_reg <= pwm_shutdown_pkg::run_st;
      cmp_hold_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cmp_hold_reg <= cmp_hold_next;
    end
  end

  // Timebase tick, one cycle behind the match
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= tick_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output pin stage
  pwm_pin_mux u_mux (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .shutdown_in(ctrl_reg[`BIT_STATUS]),
    .ac_level_in(ctrl_reg[`AC_MSB:`AC_LSB]),
    .bd_level_in(ctrl_reg[`BD_MSB:`BD_LSB]),
    .pwm_in(pwm_in),
    .pin_out(pin_out),
    .pin_oe_out(pin_oe_out)
  );

  assign prdata_out = prdata_reg;
  assign pready_out = pready_reg;
  assign pslverr_out = pslverr_reg;
  assign irq_out = irq_reg;
  assign timebase_tick_out = tick_reg;
endmodule

// ### core/pwm_shutdown_defines.svh
// Constants for the timer select and auto-shutdown block
`ifndef PWM_SHUTDOWN_DEFINES_SVH
`define PWM_SHUTDOWN_DEFINES_SVH
`define ADDR_TIMER_SELECT 12'h000
`define ADDR_SHUTDOWN_CTRL 12'h004
`define ADDR_RESTART_CTRL 12'h008
`define ADDR_IRQ_STATUS 12'h00c
`define ADDR_IRQ_CLEAR 12'h010
`define ADDR_IRQ_ENABLE 12'h014
`define RESET_BYTE 8'h00
`define BIT_STATUS 7
`define BIT_SRC2 6
`define BIT_SRC1 5
`define BIT_SRC0 4
`define BIT_RESTART 0
`define TSEL_MSB 1
`define AC_MSB 3
`define AC_LSB 2
`define BD_MSB 1
`define BD_LSB 0
`define TSEL_TIMER2 2'h0
`define TSEL_TIMER4 2'h1
`define TSEL_TIMER6 2'h2
`define LVL_LOW 2'h0
`define LVL_HIGH 2'h1
`define IRQ_SHUTDOWN 0
`define IRQ_RESTART 1
`endif

// ### core/pwm_shutdown_pkg.sv
// Types for the timer select and auto-shutdown block
package pwm_shutdown_pkg;
  typedef struct packed {
    logic first;
    logic second;
    logic third;
    logic fourth;
  } pwm_pins_t;
  typedef struct packed {
    logic int_pin;
    logic cmp2;
    logic cmp3;
    logic cmp1;
  } shutdown_inputs_t;
  typedef enum logic [1:0] {
    run_st = 2'h0,
    shut_st = 2'h1,
    wait_clear_st = 2'h3
  } shutdown_state_t;
endpackage

// ### core/pin_sync3.sv
// Three-stage synchroniser, change counts when stages two and three agree
`timescale 1ns/1ps
module pin_sync3 (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic async_in,
  output logic sync_out
);
  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic held_reg;
  logic held_next;

  // Idle high: pins are active low
  always_comb begin
    stage_next = {stage_reg[1:0], async_in};
    held_next = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : held_reg;
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      stage_reg <= 3'h7;
      held_reg <= 1'b1;
    end else begin
      stage_reg <= stage_next;
      held_reg <= held_next;
    end
  end

  assign sync_out = held_reg;
endmodule

// ### core/pwm_pin_mux.sv
// Output stage: normal PWM or programmed shutdown level per pin pair
`timescale 1ns/1ps
`include "pwm_shutdown_defines.svh"
module pwm_pin_mux (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic shutdown_in,
  input wire logic [1:0] ac_level_in,
  input wire logic [1:0] bd_level_in,
  input pwm_shutdown_pkg::pwm_pins_t pwm_in,
  output pwm_shutdown_pkg::pwm_pins_t pin_out,
  output pwm_shutdown_pkg::pwm_pins_t pin_oe_out
);
  pwm_shutdown_pkg::pwm_pins_t pin_reg;
  pwm_shutdown_pkg::pwm_pins_t pin_next;
  pwm_shutdown_pkg::pwm_pins_t oe_reg;
  pwm_shutdown_pkg::pwm_pins_t oe_next;
  logic ac_val;
  logic bd_val;
  logic ac_oe;
  logic bd_oe;

  // Upper code bit releases the pair; lower bit is the driven level
  always_comb begin
    ac_val = (ac_level_in == `LVL_HIGH);
    ac_oe = ~ac_level_in[1];
    bd_val = (bd_level_in == `LVL_HIGH);
    bd_oe = ~bd_level_in[1];
    if (shutdown_in) begin
      pin_next = '{first: ac_val & ac_oe, second: bd_val & bd_oe, third: ac_val & ac_oe, fourth: bd_val & bd_oe};
      oe_next = '{first: ac_oe, second: bd_oe, third: ac_oe, fourth: bd_oe};
    end else begin
      pin_next = pwm_in;
      oe_next = 4'hf;
    end
  end

  // Outputs off the pin until reset clears
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pin_reg <= 4'h0;
      oe_reg <= 4'h0;
    end else begin
      pin_reg <= pin_next;
      oe_reg <= oe_next;
    end
  end

  assign pin_out = pin_reg;
  assign pin_oe_out = oe_reg;
endmodule

// ### dv/pwm_load_model.sv
// Load model: the power stage as it sees the four PWM pin wires
`timescale 1ns/1ps
module pwm_load_model (
  input wire logic mclk_in,
  input pwm_shutdown_pkg::pwm_pins_t pin_in,
  input pwm_shutdown_pkg::pwm_pins_t oe_in,
  output logic [3:0] line_out
);
  logic [3:0] float_reg = 4'h5;
  // No pull on these wires, so a released pin wanders every cycle
  always_ff @(posedge mclk_in) begin
    float_reg <= ~float_reg;
  end
  // Level on each wire from its driver enable
  assign line_out = (pin_in & oe_in) | (float_reg & ~oe_in);
endmodule

// ### dv/pwm_shutdown_assertions.sv
// Port-level assertions for the timer select and auto-shutdown block
`timescale 1ns/1ps
module pwm_shutdown_assertions (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic timer2_match_in,
  input wire logic timer4_match_in,
  input wire logic timer6_match_in,
  input pwm_shutdown_pkg::pwm_pins_t pwm_in,
  input wire logic timebase_tick_out,
  input pwm_shutdown_pkg::pwm_pins_t pin_out,
  input pwm_shutdown_pkg::pwm_pins_t pin_oe_out,
  input wire logic irq_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  logic acc;
  // Access phase still waiting for its answer
  assign acc = psel_in && penable_in && !pready_out;
  ////////////////////////////////////////
  ready_wait_a: assert property (acc |=> pready_out)
    else $error("answer not one cycle after access");
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  err_timing_a: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  unmapped_err_a: assert property (acc && paddr_in > 12'h014 |=> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access not refused");
  upper_zero_a: assert property (pready_out && !pwrite_in && paddr_in == 12'h000 |-> prdata_out[31:2] == 30'h0)
    else $error("select upper bits not zero");
  tick_cause_a: assert property (timebase_tick_out |-> $past(timer2_match_in | timer4_match_in | timer6_match_in))
    else $error("tick without a timer match");
  // Enables only ever differ between the two pin pairs
  pin_pairs_a: assert property (pin_oe_out.first == pin_oe_out.third && pin_oe_out.second == pin_oe_out.fourth)
    else $error("pin pair enables differ");
  shut_level_a: assert property (pin_oe_out == 4'hf && pin_out != $past(pwm_in)
    |-> pin_out.first == pin_out.third && pin_out.second == pin_out.fourth)
    else $error("forced level differs in a pair");
  reset_quiet_a: assert property ($fell(reset_in) |-> pin_oe_out == 4'h0 && !irq_out && !pready_out)
    else $error("outputs active after reset");
endmodule

// ### dv/testbench.sv
// Self-checking testbench for the timer select and auto-shutdown block
`timescale 1ns/1ps
`include "pwm_shutdown_defines.svh"
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, err, tick, irq;
  logic int_n = 1'b1, c1_n = 1'b1, c2_n = 1'b1, c3_n = 1'b1;
  logic mod3 = 1'b0, csync = 1'b0, t1 = 1'b0;
  logic [2:0] tm = 3'h0; // Timer 2/4/6 matches
  pwm_shutdown_pkg::pwm_pins_t pwm = 4'hc, pins, oe;
  logic [3:0] line;
  // Case: trip, module three, source, control byte
  logic [11:0] cs [8] = '{12'h841, 12'ha21, 12'h321, 12'hf21, 12'h914, 12'h161, 12'h031, 12'h621};
  int num_errors = 0, cmp_count = 0;
  always #5 clk = ~clk;
  pwm_timer_shutdown DUT (.mclk_in(clk), .reset_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .int_pin_n_in(int_n), .cmp1_async_n_in(c1_n), .cmp2_async_n_in(c2_n), .cmp3_async_n_in(c3_n),
    .module_three_in(mod3), .comparator_sync_enable_in(csync), .timer1_sync_tick_in(t1),
    .timer2_match_in(tm[0]), .timer4_match_in(tm[1]), .timer6_match_in(tm[2]), .pwm_in(pwm),
    .timebase_tick_out(tick), .pin_out(pins), .pin_oe_out(oe), .irq_out(irq));
  pwm_load_model load (.mclk_in(clk), .pin_in(pins), .oe_in(oe), .line_out(line));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Request held until pready is sampled; a hang is left to the watchdog
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask
  // Pull one shutdown input: 0 int pin, 1..3 comparators
  task automatic src(input logic [1:0] k, input logic v);
    case (k)
      2'h0: int_n <= v;
      2'h1: c1_n <= v;
      2'h2: c2_n <= v;
      default: c3_n <= v;
    endcase
  endtask
  task automatic test_done;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Run needs about 540 cycles; a hang is cut well past that
  initial begin
    #100000;
    num_errors++;
    test_done;
  end
  ////////////////////////////////////////
  initial begin
    cyc(12);
    rst <= 1'b0;
    rd(`ADDR_TIMER_SELECT, 32'h0);
    rd(`ADDR_SHUTDOWN_CTRL, 32'h0);
    apb(1'b1, `ADDR_TIMER_SELECT, 32'hfc);
    rd(`ADDR_TIMER_SELECT, 32'h0);
    // Each code passes only its own timer match
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, `ADDR_TIMER_SELECT, 32'(s));
      rd(`ADDR_TIMER_SELECT, 32'(s));
      for (int m = 0; m < 3; m++) begin
        tm <= 3'h1 << m;
        cyc(1);
        tm <= 3'h0;
        cyc(1);
        chk(32'(tick), 32'(s == m));
      end
    end
    // Sources, comparator routing and forced levels; status write 0 loses
    for (int i = 0; i < 8; i++) begin
      mod3 <= cs[i][10];
      apb(1'b1, `ADDR_SHUTDOWN_CTRL, 32'(cs[i][7:0]));
      src(cs[i][9:8], 1'b0);
      cyc(10);
      rd(`ADDR_SHUTDOWN_CTRL, {24'h0, cs[i][11], cs[i][6:0]});
      chk(32'(line), cs[i][11] ? 32'({cs[i][2], cs[i][0], cs[i][2], cs[i][0]}) : 32'hc);
      apb(1'b1, `ADDR_SHUTDOWN_CTRL, 32'(cs[i][6:0]));
      rd(`ADDR_SHUTDOWN_CTRL, {24'h0, cs[i][11], cs[i][6:0]});
      src(cs[i][9:8], 1'b1);
      cyc(8);
      apb(1'b1, `ADDR_SHUTDOWN_CTRL, 32'h0);
      cyc(3);
      chk(32'(line), 32'hc);
    end
    // Tri-state codes, auto restart and event interrupts
    apb(1'b1, `ADDR_RESTART_CTRL, 32'h1);
    apb(1'b1, `ADDR_IRQ_ENABLE, 32'h3);
    apb(1'b1, `ADDR_IRQ_CLEAR, 32'h3);
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, `ADDR_SHUTDOWN_CTRL, j ? 32'h1d : 32'h1a);
      c1_n <= 1'b0;
      cyc(10);
      chk(32'(oe), j ? 32'h5 : 32'h0);
      chk(32'(irq), 32'h1);
      c1_n <= 1'b1;
      cyc(10);
      rd(`ADDR_SHUTDOWN_CTRL, j ? 32'h1d : 32'h1a);
      chk(32'(oe), 32'hf);
      rd(`ADDR_IRQ_STATUS, 32'h3);
      apb(1'b1, `ADDR_IRQ_CLEAR, 32'h3);
      cyc(2);
      chk(32'(irq), 32'h0);
    end
    // Sync mode waits for the timer1 tick; interrupt masked
    apb(1'b1, `ADDR_RESTART_CTRL, 32'h0);
    apb(1'b1, `ADDR_IRQ_ENABLE, 32'h0);
    csync <= 1'b1;
    apb(1'b1, `ADDR_SHUTDOWN_CTRL, 32'h10);
    c1_n <= 1'b0;
    cyc(10);
    rd(`ADDR_SHUTDOWN_CTRL, 32'h10);
    t1 <= 1'b1;
    cyc(1);
    t1 <= 1'b0;
    cyc(10);
    rd(`ADDR_SHUTDOWN_CTRL, 32'h90);
    rd(`ADDR_IRQ_STATUS, 32'h1);
    chk(32'(irq), 32'h0);
    rd(12'h020, 32'h0);
    chk(32'(err), 32'h1);
    test_done;
  end
endmodule
bind pwm_timer_shutdown pwm_shutdown_assertions chk_u (.mclk_in(mclk_in), .reset_in(reset_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .timer2_match_in(timer2_match_in),
  .timer4_match_in(timer4_match_in), .timer6_match_in(timer6_match_in), .pwm_in(pwm_in),
  .timebase_tick_out(timebase_tick_out), .pin_out(pin_out), .pin_oe_out(pin_oe_out), .irq_out(irq_out));
